// *** core/supervisor_pkg.sv ***
// Shared constants for the supervisory reset generator
package supervisor_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned PULSE_MS = 200;
  localparam int unsigned EXTEND_MS = 140;
  localparam int unsigned TIMEOUT_MS = 1600;
  localparam int unsigned PULSE_CYCLES = PULSE_MS * (CLK_HZ / 1000);
  localparam int unsigned EXTEND_CYCLES = EXTEND_MS * (CLK_HZ / 1000);
  localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 32;
endpackage

// *** core/supervisor_cause_if.sv ***
// Reset causes passed between the watchdog timer and the reset pulse logic
`timescale 1ns/1ps
interface supervisor_cause_if;
  logic hold_clear;
  logic expired;
  modport timer (input hold_clear, output expired);
  modport pulse (output hold_clear, input expired);
endinterface

// *** core/watchdog_timer.sv ***
// Watchdog timer: restarts on any kick edge, pulses on timeout
`timescale 1ns/1ps
module watchdog_timer #(
  parameter int unsigned TIMEOUT = supervisor_pkg::TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic kick,
  supervisor_cause_if.timer cause
);
  logic kick_q;
  logic [supervisor_pkg::CNT_W-1:0] count;
  logic hit;

  assign hit = (count == TIMEOUT[supervisor_pkg::CNT_W-1:0] - 32'h0000_0001);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      kick_q <= 1'b0;
    end else begin
      kick_q <= kick;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (cause.hold_clear) begin
      count <= '0; // R9
    end else if (kick != kick_q || hit) begin
      count <= '0; // R8
    end else begin
      count <= count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cause.expired <= 1'b0;
    end else begin
      cause.expired <= hit && !cause.hold_clear && (kick == kick_q); // R7
    end
  end
endmodule

// *** core/supervisor_watchdog_reset.sv ***
// Supervisory reset generator with manual reset and watchdog
// Notes on behaviour
// R1 - Reset is asserted while the supply is below threshold.
// R2 - Active-low reset low on low supply, manual reset low, or timeout.
// R3 - After supply recovers, reset holds for a further 200 ms pulse.
// R4 - Manual reset low triggers reset on both outputs.
// R5 - After manual reset release or timeout, hold reset 200 ms.
// R6 - Active-high reset is always the inverse of active-low reset.
// R7 - No kick level change for 1.6 s expires the watchdog.
// R8 - Either kick edge restarts the watchdog count.
// R9 - Watchdog counter is held cleared on low supply or manual reset.
// R10 - Brownout during a pulse extends it at least another 140 ms.
// R11 - Durations are counted in clock cycles with parameterised counts.
`timescale 1ns/1ps
module supervisor_watchdog_reset #(
  parameter int unsigned PULSE = supervisor_pkg::PULSE_CYCLES,
  parameter int unsigned EXTEND = supervisor_pkg::EXTEND_CYCLES,
  parameter int unsigned TIMEOUT = supervisor_pkg::TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic supply_low,
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_in,
  output logic reset_out_n,
  output logic reset_out
);
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_PULSE = 3'b010,
    ST_RUN = 3'b100
  } state_t;

  state_t state;
  state_t next_state;
  logic [supervisor_pkg::CNT_W-1:0] remain;
  logic [supervisor_pkg::CNT_W-1:0] next_remain;
  logic cause_held;

  supervisor_cause_if cause ();

  // Both level causes keep the pulse from starting and clear the watchdog
  assign cause_held = supply_low || !manual_reset_n; // R1 R4
  assign cause.hold_clear = cause_held; // R9

  watchdog_timer #(
    .TIMEOUT(TIMEOUT) // R11
  ) watchdog_timer_inst (
    .clk(clk),
    .rst_n(rst_n),
    .kick(watchdog_kick_in),
    .cause(cause)
  );

  always_comb begin
    next_state = state;
    next_remain = remain;
    case (state)
      ST_HOLD: begin
        if (!cause_held) begin
          next_state = ST_PULSE; // R3 R5
          next_remain = PULSE[supervisor_pkg::CNT_W-1:0];
        end
      end
      ST_PULSE: begin
        if (!manual_reset_n) begin
          next_state = ST_HOLD;
        end else if (supply_low) begin
          // Brownout mid-pulse: keep the rest, but never less than the extension
          next_state = ST_PULSE;
          if (remain < EXTEND[supervisor_pkg::CNT_W-1:0]) begin
            next_remain = EXTEND[supervisor_pkg::CNT_W-1:0]; // R10
          end
        end else if (remain <= 32'h0000_0001) begin
          next_state = ST_RUN;
          next_remain = '0;
        end else begin
          next_remain = remain - 32'h0000_0001; // R11
        end
      end
      ST_RUN: begin
        if (cause_held) begin
          next_state = ST_HOLD; // R1 R4
        end else if (cause.expired) begin
          next_state = ST_PULSE; // R7 R5
          next_remain = PULSE[supervisor_pkg::CNT_W-1:0];
        end
      end
      default: begin
        next_state = ST_HOLD;
        next_remain = '0;
      end
    endcase
  end

  // Power-on starts in hold so the first release still gets a full pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_HOLD;
      remain <= '0;
    end else begin
      state <= next_state;
      remain <= next_remain;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_out_n <= 1'b0;
      reset_out <= 1'b1;
    end else begin
      reset_out_n <= (next_state == ST_RUN) && !cause_held; // R2
      reset_out <= !((next_state == ST_RUN) && !cause_held); // R6
    end
  end
endmodule

// *** verification/sup_props.sv ***
// Checker for the supervisory reset outputs
`timescale 1ns/1ps
module sup_props #(parameter int unsigned TIMEOUT = 100) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic supply_low,
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_in,
  input wire logic reset_out_n,
  input wire logic reset_out
);
  int unsigned idle;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Cycles with no cause and no kick change
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) idle <= 0;
    else if (supply_low || !manual_reset_n || $changed(watchdog_kick_in)) idle <= 0;
    else idle <= idle + 1;
  a_out_inverse: assert property (reset_out == !reset_out_n)
    else $error("outputs not inverse");
  a_supply_low: assert property (supply_low |=> !reset_out_n)
    else $error("no reset on low supply");
  a_manual_low: assert property (!manual_reset_n |=> !reset_out_n)
    else $error("no reset on manual");
  a_supply_hold: assert property ($fell(supply_low) |-> !reset_out_n [*8])
    else $error("supply pulse short");
  a_manual_hold: assert property ($rose(manual_reset_n) |-> !reset_out_n [*8])
    else $error("manual pulse short");
  a_power_hold: assert property ($rose(rst_n) |-> !reset_out_n [*8])
    else $error("power-on pulse short");
  a_dog_expiry: assert property (idle == TIMEOUT + 2 |-> !reset_out_n)
    else $error("no watchdog expiry");
  a_no_early: assert property ($fell(reset_out_n) |->
    $past(supply_low) || !$past(manual_reset_n) || idle + 2 >= TIMEOUT)
    else $error("reset without cause");
endmodule
bind supervisor_watchdog_reset sup_props #(.TIMEOUT(TIMEOUT)) sup_props_inst (.*);

// *** verification/cpu_model.sv ***
// Processor model kicking the watchdog while out of reset
`timescale 1ns/1ps
module cpu_model (
  input wire logic clk,
  input wire logic reset_out,
  input wire logic kick_en,
  output logic kick
);
  int n = 0;
  initial kick = 0;
  // Toggling uses rising and falling edges alike
  always @(posedge clk) begin
    n <= (reset_out || n == 40) ? 0 : n + 1;
    if (kick_en && n == 40) kick <= #1 ~kick;
  end
endmodule

// *** verification/supervisor_watchdog_reset_tb_top.sv ***
// Self-checking bench for the supervisory reset generator
`timescale 1ns/1ps
module supervisor_watchdog_reset_tb_top;
  logic clk = 0, rst_n = 0, supply_low = 1, manual_reset_n = 1, kick_en = 1;
  logic kick, reset_out_n, reset_out;
  int n_errors = 0, n_compared = 0, c;
  always #20 clk = ~clk;
  supervisor_watchdog_reset #(.PULSE(20), .EXTEND(14), .TIMEOUT(100))
    supervisor_watchdog_reset_inst (.clk(clk), .rst_n(rst_n), .supply_low(supply_low),
    .manual_reset_n(manual_reset_n), .watchdog_kick_in(kick), .reset_out_n(reset_out_n),
    .reset_out(reset_out));
  cpu_model cpu_model_inst (.clk(clk), .reset_out(reset_out), .kick_en(kick_en), .kick(kick));
  task check(input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %b", $time, seen);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Cycles until reset_out_n reaches lvl, up to three cycles late, never early
  task wait_for(input logic lvl, input int lo);
    c = 0;
    while (reset_out_n !== lvl && c < 300) begin
      cyc(1);
      c++;
    end
    check(c >= lo && c <= lo + 3, 1);
  endtask
  task finish_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    finish_test;
  end
  initial begin
    cyc(6);
    rst_n = 1;
    cyc(4);
    check(reset_out_n, 0);
    supply_low = 0;
    wait_for(1, 20);
    check(reset_out, 0);
    manual_reset_n = 0;
    cyc(4);
    check(reset_out, 1);
    manual_reset_n = 1;
    wait_for(1, 20);
    // Brownout late in the pulse, when less than the extension remains
    supply_low = 1;
    cyc(2);
    supply_low = 0;
    cyc(15);
    supply_low = 1;
    cyc(2);
    supply_low = 0;
    wait_for(1, 14);
    kick_en = 0;
    manual_reset_n = 0;
    cyc(2);
    manual_reset_n = 1;
    wait_for(1, 20);
    wait_for(0, 79);
    kick_en = 1;
    wait_for(1, 20);
    cyc(300);
    check(reset_out_n, 1);
    finish_test;
  end
endmodule
